// ==== fault_cfg_monitor.sv ====
// Purpose: port-level checks of the fault mask and phase configuration block
// Assumes: one clock domain, reset_n active low
// Notes: mask contents are hidden here, so outputs are bounded by their sources
`timescale 1ns/1ps
module fault_cfg_monitor
(
	input wire logic clk_sys, // system clock
	input wire logic reset_n, // reset, active low
	input wire logic [fault_cfg_pkg::FAULT_W-1:0] fault_source, // raw fault events
	input wire logic [fault_cfg_pkg::TRIP_W-1:0] trip_source, // raw trip events
	input wire logic [fault_cfg_pkg::PHASES-1:0] phase_pwm, // pulse-width per phase
	input wire logic [fault_cfg_pkg::PHASES-1:0] low_side_drive, // low-side per phase
	input wire logic [fault_cfg_pkg::PINS-1:0] phase_output_pin, // mapped pins
	input wire logic fault_pin_a, // first fault pin
	input wire logic fault_pin_b, // second fault pin
	input wire logic trip_request, // shutdown request
	input wire logic scl_in, // serial clock
	input wire logic sda_out, // serial drive value
	input wire logic sda_oe // serial drive enable
);
	import fault_cfg_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// =======================================================
	// fault and trip outputs need an active source one cycle earlier
	property p_a_quiet; fault_source == '0 |=> !fault_pin_a; endproperty
	a_a_quiet: assert property (p_a_quiet) else $error("fault pin a without source");
	property p_b_quiet; fault_source == '0 |=> !fault_pin_b; endproperty
	a_b_quiet: assert property (p_b_quiet) else $error("fault pin b without source");
	property p_trip_quiet; trip_source == '0 |=> !trip_request; endproperty
	a_trip_quiet: assert property (p_trip_quiet) else $error("trip without source");
	property p_trip_cause; $rose(trip_request) |-> $past(trip_source) != '0; endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip rose with no source");
	property p_a_cause; $rose(fault_pin_a) |-> $past(fault_source) != '0; endproperty
	a_a_cause: assert property (p_a_cause) else $error("fault pin a rose with no source");
	property p_b_cause; $rose(fault_pin_b) |-> $past(fault_source) != '0; endproperty
	a_b_cause: assert property (p_b_cause) else $error("fault pin b rose with no source");
	// =======================================================
	// drive pins only carry what the phases offered
	property p_pins_quiet; phase_pwm == '0 && low_side_drive == '0 |=> phase_output_pin == '0; endproperty
	a_pins_quiet: assert property (p_pins_quiet) else $error("drive pin without phase signal");
	property p_pins_count;
		$countones(phase_output_pin) <= $countones($past(phase_pwm)) + $countones($past(low_side_drive));
	endproperty
	a_pins_count: assert property (p_pins_count) else $error("more drive pins than phase signals");
	// =======================================================
	// serial pin is open drain and only turns on while scl is low
	property p_sda_low; sda_out == 1'b0; endproperty
	a_sda_low: assert property (p_sda_low) else $error("serial drive value not low");
	property p_oe_scl; $rose(sda_oe) |-> !scl_in; endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("serial data turned on while scl high");
	// a release while scl is high would look like a stop to every other device
	property p_oe_release; $fell(sda_oe) |-> !scl_in; endproperty
	a_oe_release: assert property (p_oe_release) else $error("serial data released while scl high");
endmodule
bind fault_mask_phase_config fault_cfg_monitor mon (.clk_sys, .reset_n, .fault_source, .trip_source, .phase_pwm,
	.low_side_drive, .phase_output_pin, .fault_pin_a, .fault_pin_b, .trip_request, .scl_in, .sda_out, .sda_oe);

// ==== fault_cfg_pkg.sv ====
// Purpose: shared constants for the fault mask and phase configuration block
// Assumes: 16-bit register words reached through the two-wire serial port
// Notes: register offsets are 16-bit word addresses on the serial port
package fault_cfg_pkg;
	// =======================================================
	// serial port
	localparam logic [5:0] DEV_ADDR_UPPER = 6'h38; // 1110_00x, low bit from a pin
	// =======================================================
	// register offsets
	localparam logic [15:0] REG_DRIVER_STYLE = 16'h0010;
	localparam logic [15:0] REG_OUTPUT_MAP = 16'h0011;
	localparam logic [15:0] REG_PHASE_SELECT = 16'h0012;
	localparam logic [15:0] REG_PIN_A_LOW = 16'h0013;
	localparam logic [15:0] REG_PIN_A_HIGH = 16'h0014;
	localparam logic [15:0] REG_PIN_B_LOW = 16'h0015;
	localparam logic [15:0] REG_PIN_B_HIGH = 16'h0016;
	localparam logic [15:0] REG_TRIP_ENABLE = 16'h0017;
	localparam logic [15:0] REG_SOURCE_LOW = 16'h0018;
	localparam logic [15:0] REG_SOURCE_HIGH = 16'h0019;
	localparam logic [15:0] REG_OUT_STATUS = 16'h001a;
	// =======================================================
	// widths and reset values
	localparam int FAULT_W = 18;
	localparam int TRIP_W = 16;
	localparam int PHASES = 6;
	localparam int PINS = 12;
	localparam logic [17:0] FAULT_USED_MASK = 18'h3fffb; // bit 2 has no source
	localparam logic [17:0] PIN_ENABLE_RESET = 18'h00000;
	localparam logic [15:0] TRIP_ENABLE_RESET = 16'h0000;
	localparam logic [5:0] PHASE_SELECT_RESET = 6'h3f;
	localparam logic DRIVER_STYLE_RESET = 1'b0;
	localparam logic OUTPUT_MAP_RESET = 1'b0;
	// =======================================================
	// serial port states
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_TX_ACK = 3'b100
	} port_state_t;
endpackage

// ==== fault_mask_phase_config.sv ====
// Purpose: fault pin aggregation, trip request, phase drive mapping and serial register port
// Assumes: fault and trip sources come from logic on clk_sys; scl and sda come from pins
// Notes: no clock stretching, unmapped reads return zero and unmapped writes are dropped
`timescale 1ns/1ps
module fault_mask_phase_config
(
	input wire logic clk_sys, // 10 MHz system clock
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic [fault_cfg_pkg::FAULT_W-1:0] fault_source, // raw fault events, same clock
	input wire logic [fault_cfg_pkg::TRIP_W-1:0] trip_source, // raw shutdown events, same clock
	input wire logic [fault_cfg_pkg::PHASES-1:0] phase_pwm, // pulse-width signal per phase
	input wire logic [fault_cfg_pkg::PHASES-1:0] low_side_drive, // low-side drive per phase
	output logic [fault_cfg_pkg::PINS-1:0] phase_output_pin, // mapped drive pins
	output logic fault_pin_a, // first fault output
	output logic fault_pin_b, // second fault output
	output logic trip_request, // converter shutdown request
	input wire logic addr_select, // low bit of serial device address
	input wire logic scl_in, // serial clock from pin
	input wire logic sda_in, // serial data from pin
	output logic sda_out, // serial data drive value, always low
	output logic sda_oe // high while pulling serial data low
);
	import fault_cfg_pkg::*;

	// =======================================================
	// configuration registers
	logic driver_input_style;
	logic output_map_select;
	logic [5:0] active_phase_select;
	logic [17:0] fault_pin_a_enable;
	logic [17:0] fault_pin_b_enable;
	logic [15:0] trip_source_enable;

	// =======================================================
	// pin synchronisers; the third stage only feeds edge detection
	logic scl_meta, scl_sync, scl_prev;
	logic sda_meta, sda_sync, sda_prev;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			scl_prev <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_meta <= scl_in;
			scl_sync <= scl_meta;
			scl_prev <= scl_sync;
			sda_meta <= sda_in;
			sda_sync <= sda_meta;
			sda_prev <= sda_sync;
		end
	end

	// bus events seen on the synchronised lines
	wire scl_rise = scl_sync & ~scl_prev;
	wire scl_fall = ~scl_sync & scl_prev;
	wire bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
	wire bus_stop = scl_sync & scl_prev & ~sda_prev & sda_sync;

	// =======================================================
	// serial port state
	port_state_t state;
	logic [3:0] bit_count;
	logic [7:0] shift;
	logic [7:0] tx_shift;
	logic [1:0] byte_index;
	logic control_byte;
	logic reading;
	logic tx_low_next;
	logic master_acked;
	logic [15:0] cur_addr;
	logic [7:0] data_high;

	// received byte decode
	wire byte_done = (state == ST_RX) && (bit_count == 4'h8) && scl_fall;
	wire addr_match = (shift[7:1] == {DEV_ADDR_UPPER, addr_select});
	wire reg_write = byte_done && !control_byte && (byte_index == 2'h3);
	wire [15:0] write_word = {data_high, shift};

	// read-back selection; unmapped offsets read as zero
	logic [15:0] read_word;
	always_comb
	begin
		case (cur_addr)
			REG_DRIVER_STYLE: read_word = {15'h0000, driver_input_style};
			REG_OUTPUT_MAP: read_word = {15'h0000, output_map_select};
			REG_PHASE_SELECT: read_word = {10'h000, active_phase_select};
			REG_PIN_A_LOW: read_word = fault_pin_a_enable[15:0];
			REG_PIN_A_HIGH: read_word = {14'h0000, fault_pin_a_enable[17:16]};
			REG_PIN_B_LOW: read_word = fault_pin_b_enable[15:0];
			REG_PIN_B_HIGH: read_word = {14'h0000, fault_pin_b_enable[17:16]};
			REG_TRIP_ENABLE: read_word = trip_source_enable;
			REG_SOURCE_LOW: read_word = fault_source[15:0];
			REG_SOURCE_HIGH: read_word = {14'h0000, fault_source[17:16]};
			REG_OUT_STATUS: read_word = {13'h0000, trip_request, fault_pin_b, fault_pin_a};
			default: read_word = 16'h0000;
		endcase
	end

	// =======================================================
	// serial protocol engine: sample on scl rise, change sda on scl fall
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= ST_IDLE;
			bit_count <= 4'h0;
			shift <= 8'h00;
			tx_shift <= 8'h00;
			byte_index <= 2'h0;
			control_byte <= 1'b0;
			reading <= 1'b0;
			tx_low_next <= 1'b0;
			master_acked <= 1'b0;
			cur_addr <= 16'h0000;
			data_high <= 8'h00;
			sda_oe <= 1'b0;
		end
		else if (bus_stop)
		begin
			state <= ST_IDLE;
			sda_oe <= 1'b0;
		end
		else if (bus_start)
		begin
			state <= ST_RX;
			bit_count <= 4'h0;
			control_byte <= 1'b1;
			byte_index <= 2'h0;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (state)
				ST_RX:
				begin
					if (scl_rise && bit_count != 4'h8)
					begin
						shift <= {shift[6:0], sda_sync};
						bit_count <= bit_count + 4'h1;
					end
					else if (byte_done)
					begin
						// each accepted byte is acknowledged
						if (control_byte)
						begin
							state <= addr_match ? ST_ACK : ST_IDLE;
							sda_oe <= addr_match;
							reading <= shift[0];
						end
						else
						begin
							state <= ST_ACK;
							sda_oe <= 1'b1;
							case (byte_index)
								2'h0: cur_addr[15:8] <= shift;
								2'h1: cur_addr[7:0] <= shift;
								2'h2: data_high <= shift;
								default: data_high <= data_high;
							endcase
							if (byte_index != 2'h3)
								byte_index <= byte_index + 2'h1;
						end
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						bit_count <= 4'h0;
						if (control_byte && reading)
						begin
							// high byte goes first on a read
							state <= ST_TX;
							tx_shift <= read_word[15:8];
							sda_oe <= ~read_word[15];
							tx_low_next <= 1'b1;
						end
						else
						begin
							state <= ST_RX;
							sda_oe <= 1'b0;
						end
						control_byte <= 1'b0;
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						if (bit_count == 4'h7)
						begin
							state <= ST_TX_ACK;
							sda_oe <= 1'b0;
						end
						else
						begin
							tx_shift <= {tx_shift[6:0], 1'b0};
							sda_oe <= ~tx_shift[6];
							bit_count <= bit_count + 4'h1;
						end
					end
				end
				ST_TX_ACK:
				begin
					if (scl_rise)
						master_acked <= ~sda_sync;
					else if (scl_fall)
					begin
						// a not-acknowledge from the master ends the read
						if (master_acked)
						begin
							state <= ST_TX;
							bit_count <= 4'h0;
							tx_shift <= tx_low_next ? read_word[7:0] : read_word[15:8];
							sda_oe <= tx_low_next ? ~read_word[7] : ~read_word[15];
							tx_low_next <= ~tx_low_next;
						end
						else
							state <= ST_IDLE;
					end
				end
				default:
				begin
					state <= ST_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// open-drain: only ever pull low
	assign sda_out = 1'b0;

	// =======================================================
	// register writes; bit 2 of the pin masks has no source and stays zero
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			driver_input_style <= DRIVER_STYLE_RESET;
			output_map_select <= OUTPUT_MAP_RESET;
			active_phase_select <= PHASE_SELECT_RESET;
			fault_pin_a_enable <= PIN_ENABLE_RESET;
			fault_pin_b_enable <= PIN_ENABLE_RESET;
			trip_source_enable <= TRIP_ENABLE_RESET;
		end
		else if (reg_write)
		begin
			case (cur_addr)
				REG_DRIVER_STYLE: driver_input_style <= write_word[0];
				REG_OUTPUT_MAP: output_map_select <= write_word[0];
				REG_PHASE_SELECT: active_phase_select <= write_word[5:0];
				REG_PIN_A_LOW: fault_pin_a_enable[15:0] <= write_word & FAULT_USED_MASK[15:0];
				REG_PIN_A_HIGH: fault_pin_a_enable[17:16] <= write_word[1:0];
				REG_PIN_B_LOW: fault_pin_b_enable[15:0] <= write_word & FAULT_USED_MASK[15:0];
				REG_PIN_B_HIGH: fault_pin_b_enable[17:16] <= write_word[1:0];
				REG_TRIP_ENABLE: trip_source_enable <= write_word;
				default: trip_source_enable <= trip_source_enable;
			endcase
		end
	end

	// =======================================================
	// fault aggregation; source bit positions are fixed by the mask layout
	wire [17:0] pin_a_hits = fault_source & fault_pin_a_enable & FAULT_USED_MASK;
	wire [17:0] pin_b_hits = fault_source & fault_pin_b_enable & FAULT_USED_MASK;
	wire [15:0] trip_hits = trip_source & trip_source_enable;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fault_pin_a <= 1'b0;
			fault_pin_b <= 1'b0;
			trip_request <= 1'b0;
		end
		else
		begin
			fault_pin_a <= |pin_a_hits;
			fault_pin_b <= |pin_b_hits;
			trip_request <= |trip_hits;
		end
	end

	// =======================================================
	// phase drive mapping; a gap in the phase select is not repaired here
	wire [5:0] pwm_gated = phase_pwm & active_phase_select;
	wire [5:0] low_gated = low_side_drive & active_phase_select & {6{driver_input_style}};
	logic [11:0] next_pins;

	always_comb
	begin
		next_pins = 12'h000;
		for (int k = 0; k < PHASES; k++)
		begin
			if (output_map_select)
			begin
				next_pins[k] = pwm_gated[k];
				next_pins[k + PHASES] = low_gated[k];
			end
			else
			begin
				next_pins[2 * k] = pwm_gated[k];
				next_pins[2 * k + 1] = low_gated[k];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			phase_output_pin <= 12'h000;
		else
			phase_output_pin <= next_pins;
	end
endmodule

// ==== fault_mask_phase_config_tb_top.sv ====
// Purpose: register-level test of fault masks, trip mask and phase mapping
// Assumes: serial port at about 1 MHz scl, well inside the slowest allowed timing
// Notes: every wait is a fixed count; a watchdog ends a hang
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module fault_mask_phase_config_tb_top;
	import fault_cfg_pkg::*;
	logic clk_sys = 0;
	logic reset_n = 0;
	logic [17:0] fault_source = '0;
	logic [15:0] trip_source = '0;
	logic [5:0] phase_pwm = '0;
	logic [5:0] low_side_drive = '0;
	logic scl = 1;
	logic m_sda = 1;
	logic clear = 1;
	logic [11:0] phase_output_pin;
	logic fault_pin_a, fault_pin_b, trip_request, sda_out, sda_oe, ack;
	logic [11:0] seen_high, e_pins;
	logic [15:0] rd;
	logic [7:0] q8;
	logic [17:0] m;
	int n_errors = 0;
	int total_checks = 0;
	logic [5:0] ps_tbl [5] = '{6'h3f, 6'h07, 6'h03, 6'h0f, 6'h1f};
	logic [15:0] ra [6] = '{REG_DRIVER_STYLE, REG_OUTPUT_MAP, REG_PHASE_SELECT, REG_PIN_B_HIGH, REG_TRIP_ENABLE, 16'h0000};
	logic [15:0] rv [6] = '{{15'h0, DRIVER_STYLE_RESET}, {15'h0, OUTPUT_MAP_RESET}, {10'h0, PHASE_SELECT_RESET},
		{14'h0, PIN_ENABLE_RESET[17:16]}, TRIP_ENABLE_RESET, 16'h0000};
	// pulled-up serial data wire
	wire sda_w = (sda_oe ? sda_out : 1'b1) & m_sda;
	fault_mask_phase_config DUT (.clk_sys, .reset_n, .fault_source, .trip_source, .phase_pwm, .low_side_drive,
		.phase_output_pin, .fault_pin_a, .fault_pin_b, .trip_request, .addr_select(1'b1), .scl_in(scl),
		.sda_in(sda_w), .sda_out, .sda_oe);
	gate_driver_model drivers (.clk_sys, .clear, .drive_pin(phase_output_pin), .seen_high);
	initial
		forever #50 clk_sys = ~clk_sys;
	// =======================================================
	// serial master
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// data moves only while scl is low, so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		m_sda <= b;
		cyc(1);
		scl <= 1'b1;
		cyc(5);
		r = sda_w;
		scl <= 1'b0;
		cyc(4);
	endtask
	task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, a);
	endtask
	task automatic start_cond();
		m_sda <= 1'b0;
		cyc(5);
		scl <= 1'b0;
		cyc(4);
	endtask
	task automatic stop_cond();
		m_sda <= 1'b0;
		cyc(2);
		scl <= 1'b1;
		cyc(5);
		m_sda <= 1'b1;
		cyc(5);
	endtask
	task automatic put(input logic [7:0] d);
		byte_io(d, 1'b1, q8, ack);
		`CHK("ack", 1'b0, ack)
	endtask
	task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
		start_cond();
		put({DEV_ADDR_UPPER, 2'b10});
		put(a[15:8]);
		put(a[7:0]);
		put(d[15:8]);
		put(d[7:0]);
		stop_cond();
	endtask
	task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
		start_cond();
		put({DEV_ADDR_UPPER, 2'b10});
		put(a[15:8]);
		put(a[7:0]);
		stop_cond();
		start_cond();
		put({DEV_ADDR_UPPER, 2'b11});
		byte_io(8'hff, 1'b0, d[15:8], ack);
		byte_io(8'hff, 1'b1, d[7:0], ack);
		stop_cond();
	endtask
	function automatic logic [11:0] pins_of(input logic sty, input logic map, input logic [5:0] ps);
		logic [11:0] p;
		for (int k = 0; k < 6; k++)
		begin
			p[map ? k : 2 * k] = phase_pwm[k] & ps[k];
			p[map ? k + 6 : 2 * k + 1] = low_side_drive[k] & ps[k] & sty;
		end
		return p;
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// =======================================================
	// scenarios
	initial
	begin
		cyc(6);
		reset_n <= 1'b1;
		clear <= 1'b0;
		cyc(4);
		// reset values and an unmapped word
		for (int r = 0; r < 6; r++)
		begin
			reg_read(ra[r], rd);
			`CHK("reset value", rv[r], rd)
		end
		// a foreign device address gets no acknowledge
		start_cond();
		byte_io({DEV_ADDR_UPPER, 2'b00}, 1'b1, q8, ack);
		`CHK("foreign ack", 1'b1, ack)
		stop_cond();
		// one source at a time on pin a, all the others on pin b
		for (int i = 0; i < 18; i++)
		begin
			m = 18'h1 << i;
			reg_write(REG_PIN_A_LOW, m[15:0]);
			reg_write(REG_PIN_A_HIGH, {14'h0, m[17:16]});
			reg_write(REG_PIN_B_LOW, ~m[15:0]);
			reg_write(REG_PIN_B_HIGH, {14'h0, ~m[17:16]});
			fault_source <= m;
			cyc(2);
			`CHK("pin a", FAULT_USED_MASK[i], fault_pin_a)
			`CHK("pin b", 1'b0, fault_pin_b)
			fault_source <= ~m;
			cyc(2);
			`CHK("pin a", 1'b0, fault_pin_a)
			`CHK("pin b", 1'b1, fault_pin_b)
		end
		// raw sources and output status read back; the last pass leaves only pin b active
		reg_read(REG_SOURCE_LOW, rd);
		`CHK("source low", 16'hffff, rd)
		reg_read(REG_SOURCE_HIGH, rd);
		`CHK("source high", 16'h0001, rd)
		reg_read(REG_OUT_STATUS, rd);
		`CHK("out status", 16'h0002, rd)
		reg_write(REG_PIN_A_LOW, 16'hffff);
		reg_read(REG_PIN_A_LOW, rd);
		`CHK("mask read", FAULT_USED_MASK[15:0], rd)
		// one trip source at a time
		for (int j = 0; j < 16; j++)
		begin
			reg_write(REG_TRIP_ENABLE, 16'h1 << j);
			trip_source <= 16'h1 << j;
			cyc(2);
			`CHK("trip", 1'b1, trip_request)
			trip_source <= ~(16'h1 << j);
			cyc(2);
			`CHK("trip", 1'b0, trip_request)
		end
		// driver style, pin map and contiguous phase counts
		phase_pwm <= 6'h2d;
		low_side_drive <= 6'h3b;
		for (int s = 0; s < 5; s++)
		begin
			reg_write(REG_DRIVER_STYLE, {15'h0, s[0]});
			reg_write(REG_OUTPUT_MAP, {15'h0, s[1]});
			reg_write(REG_PHASE_SELECT, {10'h0, ps_tbl[s]});
			clear <= 1'b1;
			cyc(1);
			clear <= 1'b0;
			cyc(2);
			e_pins = pins_of(s[0], s[1], ps_tbl[s]);
			`CHK("pins", e_pins, phase_output_pin)
			`CHK("driver record", e_pins, seen_high)
		end
		end_of_test();
	end
	initial
	begin
		cyc(100000);
		n_errors++;
		end_of_test();
	end
endmodule

// ==== gate_driver_model.sv ====
// Purpose: gate driver stand-in that records which drive pins switched on
// Assumes: drive pins are active high levels
// Notes: the record is sticky because the bench looks long after the pulse
`timescale 1ns/1ps
module gate_driver_model
(
	input wire logic clk_sys, // system clock
	input wire logic clear, // restarts the record
	input wire logic [11:0] drive_pin, // mapped drive pins
	output logic [11:0] seen_high // pins that drove a switch on
);
	// a single-input driver only listens on its pulse pin; the bench decides which pins count
	always_ff @(posedge clk_sys)
	begin
		seen_high <= clear ? 12'h000 : seen_high | drive_pin;
	end
endmodule
